// ===== logic/fsps_sequencer.v
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "fsps_defs.vh"
// Notes on behaviour
// - Erase only whole rows of flash
// - Erase select reads set until erase done
// - Two setup cycles after go set
// - Erase stalls CPU about 2 ms
// - CPU resumes after stall ends
// - Writes never erase automatically
// - At most 32 words per write
// - Latch block aligned, never crossed
// - Latches reset to 3FFF after write
// - Latch-only mode just loads one latch
// - Otherwise load last latch, program block
// - Whole latch block always programmed
// - No stall for latch loads; stall on write
module fsps_sequencer #(
  parameter OP_CYCLES = `FSPS_OP_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire cpu_stall,
  output reg flash_erase_row,
  output reg flash_program_word,
  output reg [14:0] flash_addr,
  output reg [13:0] flash_wdata
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_SETUP = 4'b0010;
  localparam ST_ERASE = 4'b0100;
  localparam ST_PROG = 4'b1000;

  reg [7:0] addr_low_r;
  reg [6:0] addr_high_r;
  reg [7:0] data_low_r;
  reg [5:0] data_high_r;
  reg [7:0] ctrl_r;
  reg [1:0] unlock_r;
  reg [3:0] state_r;
  reg [21:0] count_r;
  reg op_erase_r;
  reg [5:0] prog_idx_r;
  reg prog_rd_r;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [14:0] pm_addr = {addr_high_r, addr_low_r};
  wire [13:0] pm_data = {data_high_r, data_low_r};
  wire [13:0] latch_rd;
  wire busy = (state_r != ST_IDLE);
  // Store the word only when the go really starts
  wire go_req;
  wire latch_ld;
  wire latch_clr;

  // Decode one register offset
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // stall during erase or block-write setup and flash work only
  assign cpu_stall = (state_r == ST_ERASE) || (state_r == ST_PROG) ||
                     ((state_r == ST_SETUP) && !ctrl_r[`FSPS_BIT_LATCH_ONLY] && !op_erase_r) ||
                     ((state_r == ST_SETUP) && op_erase_r);

  // go honoured only straight after both keys with enable set
  assign go_req = wr && hit(paddr, `FSPS_OFF_CONTROL) && pwdata[`FSPS_BIT_GO] &&
                  !ctrl_r[`FSPS_BIT_GO] && (unlock_r == 2'd2) && ctrl_r[`FSPS_BIT_ENABLE] &&
                  pwdata[`FSPS_BIT_ENABLE] && pwdata[`FSPS_BIT_PROGRAM] && !pwdata[`FSPS_BIT_CONFIG] && !busy;
  // every non-erase go loads the addressed latch
  assign latch_ld = go_req && !pwdata[`FSPS_BIT_ERASE];
  // latches return to erased value after the block write
  assign latch_clr = (state_r == ST_PROG) && (count_r == 22'd1);

  // latch index is low address bits, never crosses block
  fsps_latch_mem u_latch (
    .pclk(pclk),
    .presetn(presetn),
    .clear(latch_clr),
    .wr_en(latch_ld),
    .wr_idx(pm_addr[4:0]),
    .wr_data(pm_data),
    .rd_idx(prog_idx_r[4:0]),
    .rd_data(latch_rd)
  );

  // Unlock tracker: any other write breaks the key sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= 2'd0;
    end else if (wr) begin
      if (hit(paddr, `FSPS_OFF_UNLOCK) && pwdata[7:0] == `FSPS_KEY1) begin
        unlock_r <= 2'd1;
      end else if (hit(paddr, `FSPS_OFF_UNLOCK) && pwdata[7:0] == `FSPS_KEY2 && unlock_r == 2'd1) begin
        unlock_r <= 2'd2;
      end else begin
        unlock_r <= 2'd0;
      end
    end
  end

  // Address, data and control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_r <= 8'h00;
      addr_high_r <= 7'h00;
      data_low_r <= 8'h00;
      data_high_r <= 6'h00;
      ctrl_r <= 8'h00;
    end else begin
      // Operand registers locked while the sequencer works
      if (wr && !busy && hit(paddr, `FSPS_OFF_ADDR_LOW)) addr_low_r <= pwdata[7:0];
      if (wr && !busy && hit(paddr, `FSPS_OFF_ADDR_HIGH)) addr_high_r <= pwdata[6:0];
      if (wr && !busy && hit(paddr, `FSPS_OFF_DATA_LOW)) data_low_r <= pwdata[7:0];
      if (wr && !busy && hit(paddr, `FSPS_OFF_DATA_HIGH)) data_high_r <= pwdata[5:0];
      if (wr && !busy && hit(paddr, `FSPS_OFF_CONTROL)) begin
        // Software cannot set go itself; only an accepted go does
        ctrl_r <= {pwdata[7:1], go_req};
      end else if ((state_r == ST_ERASE || state_r == ST_PROG) && count_r == 22'd1) begin
        // hardware ends go and erase select
        ctrl_r[`FSPS_BIT_GO] <= 1'b0;
        ctrl_r[`FSPS_BIT_ERASE] <= 1'b0;
      end else if (state_r == ST_SETUP && count_r == 22'd1 && !op_erase_r && ctrl_r[`FSPS_BIT_LATCH_ONLY]) begin
        ctrl_r[`FSPS_BIT_GO] <= 1'b0;
      end
    end
  end

  // Sequencer: setup, then erase row, program block, or back to idle after a latch-only load
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      count_r <= 22'd0;
      op_erase_r <= 1'b0;
      prog_idx_r <= 6'd0;
      prog_rd_r <= 1'b0;
      flash_erase_row <= 1'b0;
      flash_program_word <= 1'b0;
      flash_addr <= 15'h0000;
      flash_wdata <= 14'h0000;
    end else begin
      flash_erase_row <= 1'b0;
      flash_program_word <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (go_req) begin
            state_r <= ST_SETUP;
            count_r <= 22'd`FSPS_SETUP_CYCLES;
            op_erase_r <= pwdata[`FSPS_BIT_ERASE];
          end
        end
        ST_SETUP: begin
          if (count_r == 22'd1) begin
            if (op_erase_r) begin
              state_r <= ST_ERASE;
              count_r <= OP_CYCLES[21:0];
              flash_erase_row <= 1'b1;
              flash_addr <= {pm_addr[14:5], 5'h00};
            end else if (ctrl_r[`FSPS_BIT_LATCH_ONLY]) begin
              state_r <= ST_IDLE;
              count_r <= 22'd0;
            end else begin
              // stream all 32 latches, no erase
              state_r <= ST_PROG;
              count_r <= OP_CYCLES[21:0];
              prog_idx_r <= 6'd0;
              prog_rd_r <= 1'b0;
            end
          end else begin
            count_r <= count_r - 22'd1;
          end
        end
        ST_ERASE: begin
          if (count_r == 22'd1) state_r <= ST_IDLE;
          count_r <= count_r - 22'd1;
        end
        ST_PROG: begin
          // One read cycle latency from the latch memory
          if (prog_idx_r < `FSPS_LATCHES) prog_idx_r <= prog_idx_r + 6'd1;
          prog_rd_r <= (prog_idx_r < `FSPS_LATCHES);
          if (prog_rd_r) begin
            flash_program_word <= 1'b1;
            flash_addr <= {pm_addr[14:5], prog_idx_r[4:0] - 5'd1};
            flash_wdata <= latch_rd;
          end
          if (count_r == 22'd1) state_r <= ST_IDLE;
          count_r <= count_r - 22'd1;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Read mux; the status word shows sequencer state and unlock progress
  always @* begin
    prdata = 32'h00000000;
    if (hit(paddr, `FSPS_OFF_ADDR_LOW)) prdata = {24'h000000, addr_low_r};
    else if (hit(paddr, `FSPS_OFF_ADDR_HIGH)) prdata = {25'h0, addr_high_r};
    else if (hit(paddr, `FSPS_OFF_DATA_LOW)) prdata = {24'h000000, data_low_r};
    else if (hit(paddr, `FSPS_OFF_DATA_HIGH)) prdata = {26'h0, data_high_r};
    else if (hit(paddr, `FSPS_OFF_CONTROL)) prdata = {24'h000000, ctrl_r};
    else if (hit(paddr, `FSPS_OFF_STATUS)) prdata = {26'h0, unlock_r, state_r};
  end
endmodule

// ===== logic/fsps_defs.vh
`ifndef FSPS_DEFS_VH
`define FSPS_DEFS_VH
// Register byte offsets on the APB slave
`define FSPS_OFF_ADDR_LOW 12'h000
`define FSPS_OFF_ADDR_HIGH 12'h004
`define FSPS_OFF_DATA_LOW 12'h008
`define FSPS_OFF_DATA_HIGH 12'h00c
`define FSPS_OFF_CONTROL 12'h010
`define FSPS_OFF_UNLOCK 12'h014
`define FSPS_OFF_STATUS 12'h018
// Control register fields
`define FSPS_BIT_GO 0
`define FSPS_BIT_ENABLE 2
`define FSPS_BIT_ERASE 4
`define FSPS_BIT_LATCH_ONLY 5
`define FSPS_BIT_CONFIG 6
`define FSPS_BIT_PROGRAM 7
// Unlock keys
`define FSPS_KEY1 8'h55
`define FSPS_KEY2 8'haa
// Latch geometry and erased value
`define FSPS_LATCHES 32
`define FSPS_LATCH_AW 5
`define FSPS_WORD_W 14
`define FSPS_ERASED 14'h3fff
// Timing: 2 ms operation, 2 setup cycles, 20 ns clock
`define FSPS_OP_TIME_NS 2000000
`define FSPS_CLK_NS 20
`define FSPS_OP_CYCLES (`FSPS_OP_TIME_NS / `FSPS_CLK_NS)
`define FSPS_SETUP_CYCLES 2
`endif

// ===== logic/fsps_latch_mem.v
`timescale 1ns/1ns
// Write latch block; clear restores erased value everywhere
module fsps_latch_mem (
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire wr_en,
  input wire [4:0] wr_idx,
  input wire [13:0] wr_data,
  input wire [4:0] rd_idx,
  output reg [13:0] rd_data
);
`include "fsps_defs.vh"
  reg [13:0] mem_r [0:31];
  genvar g;
  // One word per latch; clear beats a load in the same cycle
  generate
    for (g = 0; g < `FSPS_LATCHES; g = g + 1) begin : gen_latch
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_r[g] <= 14'h3fff;
        end else if (clear) begin
          mem_r[g] <= `FSPS_ERASED;
        end else if (wr_en && wr_idx == g) begin
          mem_r[g] <= wr_data;
        end
      end
    end
  endgenerate
  // Registered read port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 14'h3fff;
    end else begin
      rd_data <= mem_r[rd_idx];
    end
  end
endmodule

// ===== tb/fsps_sequencer_assertions.sv
`timescale 1ns/1ns
module fsps_sequencer_assertions #(
  parameter OP_CYCLES = 50
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cpu_stall,
  input wire flash_erase_row,
  input wire flash_program_word,
  input wire [14:0] flash_addr,
  input wire [13:0] flash_wdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctl_wr = psel && penable && pwrite && (paddr == 12'h010);
  reg [7:0] pcnt_r;
  reg [17:0] scnt_r;
  // Stall length and pulses per stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt_r <= 8'h00;
      scnt_r <= 18'h00000;
    end else if (!cpu_stall) begin
      pcnt_r <= 8'h00;
      scnt_r <= 18'h00000;
    end else begin
      pcnt_r <= pcnt_r + {7'h00, flash_program_word};
      scnt_r <= scnt_r + 18'h00001;
    end
  end
  AST_ERASE_ALIGN: assert property (flash_erase_row |-> flash_addr[4:0] == 5'h00)
    else $error("erase row not aligned");
  AST_ERASE_STALL: assert property (flash_erase_row |-> cpu_stall)
    else $error("erase without stall");
  AST_NO_MIX: assert property (!(flash_erase_row && flash_program_word))
    else $error("erase mixed with program");
  AST_PROG_STALL: assert property (flash_program_word |-> cpu_stall)
    else $error("program without stall");
  AST_PROG_MAX: assert property (pcnt_r <= 8'h20)
    else $error("too many words programmed");
  AST_GO_REFUSED: assert property (ctl_wr && !pwdata[2] && !cpu_stall |=> !cpu_stall)
    else $error("go accepted while disabled");
  AST_LATCH_NO_STALL: assert property (ctl_wr && pwdata[5] && !pwdata[4] && !cpu_stall |=> !cpu_stall)
    else $error("latch load stalled");
  AST_STALL_LEN: assert property ($fell(cpu_stall) |-> $past(scnt_r) >= OP_CYCLES - 1 && $past(scnt_r) <= OP_CYCLES + 4)
    else $error("stall length wrong");
  AST_STALL_MIN: assert property ($rose(cpu_stall) |-> cpu_stall [*8])
    else $error("stall too short");
  cover property (flash_erase_row);
  cover property (flash_program_word && flash_addr[4:0] == 5'h1f);
  cover property ($fell(cpu_stall));
endmodule
bind fsps_sequencer fsps_sequencer_assertions #(.OP_CYCLES(OP_CYCLES)) fsps_sequencer_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall),
  .flash_erase_row(flash_erase_row), .flash_program_word(flash_program_word), .flash_addr(flash_addr),
  .flash_wdata(flash_wdata));

// ===== tb/fsps_sequencer_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("Error %0t got %h", $time, a); end end
module fsps_sequencer_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, seed = 32'h5a, rd;
  wire [31:0] prdata;
  wire pready, pslverr, cpu_stall, flash_erase_row, flash_program_word;
  wire [14:0] flash_addr;
  wire [13:0] flash_wdata;
  integer fail_count = 0, comparisons = 0, cyc = 0, pcnt = 0, ecnt = 0, i, k, m, n;
  reg [13:0] pmem [0:31];
  reg [13:0] exp_m [0:31];
  reg [14:0] eaddr, base, a;
  reg [9:0] pblk;
  reg [4:0] s;
  always #10 pclk = ~pclk;
  fsps_sequencer #(.OP_CYCLES(50)) fsps_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_stall(cpu_stall), .flash_erase_row(flash_erase_row),
    .flash_program_word(flash_program_word), .flash_addr(flash_addr), .flash_wdata(flash_wdata));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task complete_run;
    begin
      $display("Counts: %0d compared, %0d failed", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // One APB transfer; idle edge after so psel is never driven twice in a step
  task apb(input w, input [11:0] ad, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task unlock_go(input [7:0] c);
    begin
      apb(1, 12'h014, 32'h55);
      apb(1, 12'h014, 32'haa);
      apb(1, 12'h010, {24'h0, c});
    end
  endtask
  task wait_idle;
    begin
      n = 0;
      while (cpu_stall && n < 500) begin
        @(posedge pclk);
        n = n + 1;
      end
      `CHK(n < 500, 1'b1)
    end
  endtask
  // Flash pulse monitor and hang guard
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (flash_program_word) begin
      pmem[flash_addr[4:0]] = flash_wdata;
      pblk = flash_addr[14:5];
      pcnt = pcnt + 1;
    end
    if (flash_erase_row) begin
      eaddr = flash_addr;
      ecnt = ecnt + 1;
    end
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h010, 0);
    `CHK(rd, 32'h0)
    apb(0, 12'h018, 0);
    `CHK(rd, 32'h1)
    apb(0, 12'h01c, 0);
    `CHK(rd, 32'h0)
    `CHK({pready, pslverr}, 2'b10)
    // Go without enable, or after a broken key sequence, must not start anything
    apb(1, 12'h014, 32'h55);
    apb(1, 12'h014, 32'haa);
    apb(1, 12'h010, 32'h91);
    apb(1, 12'h010, 32'h94);
    apb(1, 12'h014, 32'h55);
    apb(1, 12'h000, 32'h12);
    apb(1, 12'h014, 32'haa);
    apb(1, 12'h010, 32'h95);
    `CHK({cpu_stall, ecnt[3:0]}, 5'h00)
    $display("test refusal done");
    seed = xs(seed);
    base = seed[14:0];
    // row address, then keys and go
    apb(1, 12'h000, {24'h0, base[7:0]});
    apb(1, 12'h004, {25'h0, base[14:8]});
    unlock_go(8'h95);
    apb(0, 12'h010, 0);
    `CHK(rd[4], 1'b1)
    wait_idle;
    `CHK({ecnt[3:0], eaddr}, {4'h1, base[14:5], 5'h00})
    apb(0, 12'h010, 0);
    `CHK(rd[4] | rd[0], 1'b0)
    $display("test erase done");
    // Partial block, then a lone word to see latches reset
    for (k = 0; k < 2; k++) begin
      m = 5 - 4 * k;
      for (i = 0; i < 32; i++) exp_m[i] = 14'h3fff;
      pcnt = 0;
      seed = xs(seed);
      s = seed[20:16] & 5'h1b;
      base = {seed[14:5], 5'h00};
      // latch-only loads, then the final word
      apb(1, 12'h010, 32'ha4);
      for (i = 0; i < m; i++) begin
        if (i == m - 1) apb(1, 12'h010, 32'h84);
        seed = xs(seed);
        a = base + s + i;
        exp_m[s + i] = seed[13:0];
        apb(1, 12'h000, {24'h0, a[7:0]});
        apb(1, 12'h004, {25'h0, a[14:8]});
        apb(1, 12'h008, {24'h0, seed[7:0]});
        apb(1, 12'h00c, {26'h0, seed[13:8]});
        unlock_go(i == m - 1 ? 8'h85 : 8'ha5);
        if (i < m - 1) `CHK({cpu_stall, pcnt[7:0]}, 9'h000)
      end
      `CHK(cpu_stall, 1'b1)
      wait_idle;
      `CHK({pcnt[7:0], pblk}, {8'h20, base[14:5]})
      for (i = 0; i < 32; i++) `CHK(pmem[i], exp_m[i])
      $display("test block %0d done", k);
    end
    complete_run;
  end
endmodule
